// ==== logic/gcd_pkg.sv ====
/*
 * Shared constants of the graphic display command decoder: command
 * codes, status bit positions, reset values, FIFO shape and timing.
 * Assumes a single 100 MHz system clock.
 */
package gcd_pkg;
    // command patterns; ? marks operand or don't-care bits
    localparam logic [7:0] CMD_DISP = 8'b1010_111?;
    localparam logic [7:0] CMD_START = 8'b01??_????;
    localparam logic [7:0] CMD_PAGE = 8'b1011_????;
    localparam logic [7:0] CMD_COL_HI = 8'b0001_????;
    localparam logic [7:0] CMD_COL_LO = 8'b0000_????;
    localparam logic [7:0] CMD_SEG = 8'b1010_000?;
    localparam logic [7:0] CMD_INV = 8'b1010_011?;
    localparam logic [7:0] CMD_ALLON = 8'b1010_010?;
    localparam logic [7:0] CMD_BIAS = 8'b1010_001?;
    localparam logic [7:0] CMD_COM = 8'b1100_????;
    localparam logic [7:0] CMD_POWER = 8'b0010_1???;
    localparam logic [7:0] CMD_REGUL = 8'b0010_0???;
    localparam logic [7:0] CMD_RMW = 8'hE0;
    localparam logic [7:0] CMD_END = 8'hEE;
    localparam logic [7:0] CMD_RESET = 8'hE2;
    localparam logic [7:0] CMD_NOP = 8'hE3;
    localparam logic [7:0] CMD_EV = 8'h81;
    localparam logic [7:0] CMD_BOOST = 8'hFC;
    // status byte layout
    localparam int ST_SEG_BIT = 6;
    localparam int ST_DISP_BIT = 5;
    localparam int ST_RST_BIT = 4;
    // field positions
    localparam int COM_BIT = 3;
    localparam int SER_SDA_BIT = 7;
    localparam int SER_SCL_BIT = 6;
    localparam logic [2:0] SER_LAST_BIT = 3'h7;
    // reset values
    localparam logic [5:0] RST_FIRST_LINE = 6'h00;
    localparam logic [3:0] RST_PAGE = 4'h0;
    localparam logic [7:0] RST_COLUMN = 8'h00;
    localparam logic [5:0] RST_CONTRAST = 6'h20;
    localparam logic [2:0] RST_REGUL = 3'h5;
    // fifo entry: {is_read, data_cmd_sel, byte}
    localparam int FIFO_WIDTH = 10;
    localparam int FIFO_DEPTH = 8;
    // initialization time after any reset
    localparam int CLK_MHZ = 100;
    localparam int INIT_NS = 1000;
    localparam int INIT_CYC = (INIT_NS * CLK_MHZ + 999) / 1000;
    localparam int INIT_W = 12;

    typedef enum logic [2:0] {
        ST_CMD = 3'b001,
        ST_EV = 3'b010,
        ST_BOOST = 3'b100
    } gcd_state_t;
endpackage

// ==== logic/gcd_decoder.sv ====
/*
 * Host command and data decoder of a 128x64 graphic display controller,
 * with its byte FIFO. Pins arrive asynchronously and are synchronised to
 * clock_i; the serial clock is oversampled, so it must stay well below
 * half the system clock rate.
 */
// Functional notes
// - data_cmd_sel low command/status, high RAM data
// - access only with chip select low; else float
// - port_type_sel and cpu_style_sel choose port type
// - hardware reset pin reinitialises all registers; fifo, holding stage and serial receiver are not cleared by it
// - 1010111x switches display on or off
// - 01xxxxxx loads display start line
// - 1011xxxx loads page address
// - 0001/0000 load column address high/low nibble
// - status read returns seg, display, reset flag
// - data write stores byte at page/column
// - data read returns byte at page/column
// - 1010000x sets segment direction
// - 1010011x selects inverse display
// - 1010010x forces every pixel on
// - 1010001x selects bias
// - E0 enters, EE leaves read-modify-write
// - E2 performs software reset
// - 1100yxxx sets common direction
// - 00101xxx switches three power stages
// - 00100xxx loads regulation ratio
// - 81 then operand sets contrast level
// - FC then operand bit 0 sets multiplier
// - display off plus all-on means power save
// - E3 changes nothing
// - don't-care bits never change decoding
`timescale 1ns/1ns

module gcd_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (count_ff != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr_ff];

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module gcd_decoder #(
    parameter int FIFO_DEPTH = gcd_pkg::FIFO_DEPTH,
    parameter int INIT_CYCLES = gcd_pkg::INIT_CYC
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic chip_select_n_i,
    input wire logic hw_reset_n_i,
    input wire logic data_cmd_sel_i,
    input wire logic rw_or_write_strobe_i,
    input wire logic enable_or_read_strobe_i,
    input wire logic cpu_style_sel_i,
    input wire logic port_type_sel_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic display_on_o,
    output logic [5:0] first_line_o,
    output logic [3:0] page_index_o,
    output logic [7:0] column_index_o,
    output logic seg_reverse_o,
    output logic com_reverse_o,
    output logic invert_pixels_o,
    output logic force_all_on_o,
    output logic bias_choice_o,
    output logic pump_multiplier_o,
    output logic [5:0] contrast_level_o,
    output logic [2:0] regul_ratio_o,
    output logic pump_on_o,
    output logic regulator_on_o,
    output logic follower_on_o,
    output logic power_save_o,
    output logic rmw_mode_o,
    output logic init_busy_o
);
    localparam int PW = 15;
    logic [PW-1:0] pin_meta_ff;
    logic [PW-1:0] pin_sync_ff;
    logic [PW-1:0] pin_prev_ff;
    logic s_psb, s_c86, s_hw_n, s_cs_n, s_a0, s_rwr, s_erd;
    logic p_cs_n, p_a0, p_rwr, p_erd;
    logic [7:0] s_data;
    logic [7:0] p_data;

    // every pin passes two flops before any logic sees it
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta_ff <= '1;
            pin_sync_ff <= '1;
            pin_prev_ff <= '1;
        end else begin
            pin_meta_ff <= {port_type_sel_i, cpu_style_sel_i, hw_reset_n_i, chip_select_n_i,
                            data_cmd_sel_i, rw_or_write_strobe_i, enable_or_read_strobe_i, data_i};
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    assign {s_psb, s_c86, s_hw_n, s_cs_n, s_a0, s_rwr, s_erd, s_data} = pin_sync_ff;
    assign {p_cs_n, p_a0, p_rwr, p_erd, p_data} = pin_prev_ff[11:0];

    // port decode: parallel when port_type_sel high, 6800 when cpu_style_sel high
    logic par_mode;
    logic m6800;
    logic wr8080, rd8080, e_fall, ev_write, ev_read;
    assign par_mode = s_psb;
    assign m6800 = s_c86;
    assign wr8080 = par_mode && !m6800 && s_rwr && !p_rwr && !p_cs_n;
    assign rd8080 = par_mode && !m6800 && s_erd && !p_erd && !p_cs_n;
    assign e_fall = par_mode && m6800 && !s_erd && p_erd && !p_cs_n;
    assign ev_write = wr8080 || (e_fall && !p_rwr);
    assign ev_read = rd8080 || (e_fall && p_rwr);

    // serial receiver: sda on bit 7, scl on bit 6 of the data pins
    logic [6:0] sh_ff;
    logic [2:0] bit_cnt_ff;
    logic scl_rise;
    logic ser_done;
    assign scl_rise = !par_mode && !s_cs_n && s_data[gcd_pkg::SER_SCL_BIT]
                      && !p_data[gcd_pkg::SER_SCL_BIT];
    assign ser_done = scl_rise && (bit_cnt_ff == gcd_pkg::SER_LAST_BIT);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sh_ff <= '0;
            bit_cnt_ff <= '0;
        end else if (s_cs_n || par_mode) begin
            bit_cnt_ff <= '0;
        end else if (scl_rise) begin
            sh_ff <= {sh_ff[5:0], s_data[gcd_pkg::SER_SDA_BIT]};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
    end

    // holding stage: a byte waits here while the fifo is full
    logic cap_valid_ff;
    logic [gcd_pkg::FIFO_WIDTH-1:0] cap_word_ff;
    logic fifo_in_ready;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cap_valid_ff <= 1'b0;
            cap_word_ff <= '0;
        end else if (ev_write || ev_read) begin
            cap_valid_ff <= 1'b1;
            cap_word_ff <= {ev_read, p_a0, p_data};
        end else if (ser_done) begin
            cap_valid_ff <= 1'b1;
            cap_word_ff <= {1'b0, s_a0, sh_ff, s_data[gcd_pkg::SER_SDA_BIT]};
        end else if (fifo_in_ready) begin
            cap_valid_ff <= 1'b0;
        end
    end

    logic fifo_valid;
    logic [gcd_pkg::FIFO_WIDTH-1:0] fifo_word;
    logic init_busy_ff;
    gcd_fifo #(
        .WIDTH(gcd_pkg::FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_valid_i(cap_valid_ff),
        .in_ready_o(fifo_in_ready),
        .in_data_i(cap_word_ff),
        .out_valid_o(fifo_valid),
        .out_ready_i(!init_busy_ff),
        .out_data_o(fifo_word)
    );

    // commands wait in the fifo until initialization is over
    logic pop, e_read, e_a0, is_cmd, dat_wr, dat_rd, soft_rst, clr;
    logic [7:0] e_byte;
    gcd_pkg::gcd_state_t state_ff;
    assign pop = fifo_valid && !init_busy_ff;
    assign {e_read, e_a0, e_byte} = fifo_word;
    assign is_cmd = pop && !e_read && !e_a0;
    assign dat_wr = pop && !e_read && e_a0;
    assign dat_rd = pop && e_read && e_a0;
    assign soft_rst = is_cmd && state_ff == gcd_pkg::ST_CMD
                      && e_byte == gcd_pkg::CMD_RESET;
    assign clr = !s_hw_n || soft_rst;

    logic [gcd_pkg::INIT_W-1:0] init_cnt_ff;
    logic [gcd_pkg::INIT_W-1:0] nxt_init_cnt;
    always_comb begin
        nxt_init_cnt = init_cnt_ff;
        if (clr) begin
            nxt_init_cnt = gcd_pkg::INIT_W'(INIT_CYCLES);
        end else if (init_cnt_ff != '0) begin
            nxt_init_cnt = init_cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            init_cnt_ff <= gcd_pkg::INIT_W'(INIT_CYCLES);
            init_busy_ff <= 1'b1;
        end else begin
            init_cnt_ff <= nxt_init_cnt;
            init_busy_ff <= (nxt_init_cnt != '0);
        end
    end

    // two-byte commands: the next command byte is taken as operand
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= gcd_pkg::ST_CMD;
        end else if (clr) begin
            state_ff <= gcd_pkg::ST_CMD;
        end else if (is_cmd) begin
            unique case (state_ff)
                gcd_pkg::ST_CMD: begin
                    if (e_byte == gcd_pkg::CMD_EV) begin
                        state_ff <= gcd_pkg::ST_EV;
                    end else if (e_byte == gcd_pkg::CMD_BOOST) begin
                        state_ff <= gcd_pkg::ST_BOOST;
                    end
                end
                gcd_pkg::ST_EV: state_ff <= gcd_pkg::ST_CMD;
                gcd_pkg::ST_BOOST: state_ff <= gcd_pkg::ST_CMD;
            endcase
        end
    end

    logic plain_cmd;
    assign plain_cmd = is_cmd && state_ff == gcd_pkg::ST_CMD;

    // display and power configuration; unknown and test codes fall through
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i || clr) begin
            display_on_o <= 1'b0;
            first_line_o <= gcd_pkg::RST_FIRST_LINE;
            seg_reverse_o <= 1'b0;
            com_reverse_o <= 1'b0;
            invert_pixels_o <= 1'b0;
            force_all_on_o <= 1'b0;
            bias_choice_o <= 1'b0;
            pump_multiplier_o <= 1'b0;
            contrast_level_o <= gcd_pkg::RST_CONTRAST;
            regul_ratio_o <= gcd_pkg::RST_REGUL;
            {pump_on_o, regulator_on_o, follower_on_o} <= 3'h0;
        end else if (is_cmd && state_ff == gcd_pkg::ST_EV) begin
            contrast_level_o <= e_byte[5:0];
        end else if (is_cmd && state_ff == gcd_pkg::ST_BOOST) begin
            pump_multiplier_o <= e_byte[0];
        end else if (plain_cmd) begin
            casez (e_byte)
                gcd_pkg::CMD_DISP: display_on_o <= e_byte[0];
                gcd_pkg::CMD_START: first_line_o <= e_byte[5:0];
                gcd_pkg::CMD_SEG: seg_reverse_o <= e_byte[0];
                gcd_pkg::CMD_INV: invert_pixels_o <= e_byte[0];
                gcd_pkg::CMD_ALLON: force_all_on_o <= e_byte[0];
                gcd_pkg::CMD_BIAS: bias_choice_o <= e_byte[0];
                gcd_pkg::CMD_COM: com_reverse_o <= e_byte[gcd_pkg::COM_BIT];
                gcd_pkg::CMD_POWER: begin
                    {pump_on_o, regulator_on_o, follower_on_o} <= e_byte[2:0];
                end
                gcd_pkg::CMD_REGUL: regul_ratio_o <= e_byte[2:0];
                default: ;
            endcase
        end
    end

    // a registered copy so power save follows its two causes by one cycle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            power_save_o <= 1'b0;
        end else begin
            power_save_o <= !display_on_o && force_all_on_o;
        end
    end

    // addressing and read-modify-write
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i || clr) begin
            page_index_o <= gcd_pkg::RST_PAGE;
            column_index_o <= gcd_pkg::RST_COLUMN;
            rmw_mode_o <= 1'b0;
        end else if (plain_cmd) begin
            casez (e_byte)
                gcd_pkg::CMD_PAGE: page_index_o <= e_byte[3:0];
                gcd_pkg::CMD_COL_HI: column_index_o[7:4] <= e_byte[3:0];
                gcd_pkg::CMD_COL_LO: column_index_o[3:0] <= e_byte[3:0];
                gcd_pkg::CMD_RMW: rmw_mode_o <= 1'b1;
                gcd_pkg::CMD_END: rmw_mode_o <= 1'b0;
                default: ;
            endcase
        end else if (dat_wr || (dat_rd && !rmw_mode_o)) begin
            column_index_o <= column_index_o + 8'h01;
        end
    end

    // display RAM, one byte per page and column
    logic [7:0] ram [2**12];
    always_ff @(posedge clock_i) begin
        if (dat_wr) begin
            ram[{page_index_o, column_index_o}] <= e_byte;
        end
    end

    // read path: the bus byte follows the select level continuously
    logic [7:0] status;
    always_comb begin
        status = 8'h00;
        status[gcd_pkg::ST_SEG_BIT] = seg_reverse_o;
        status[gcd_pkg::ST_DISP_BIT] = display_on_o;
        status[gcd_pkg::ST_RST_BIT] = init_busy_ff;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            data_o <= 8'h00;
            data_oe_o <= 1'b0;
        end else begin
            data_o <= s_a0 ? ram[{page_index_o, column_index_o}] : status;
            data_oe_o <= par_mode && !s_cs_n && (m6800 ? (s_rwr && s_erd) : !s_erd);
        end
    end

    assign init_busy_o = init_busy_ff;

    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    AST_DISP: assert property (plain_cmd && e_byte[7:1] == 7'h57 && s_hw_n
        |=> display_on_o == $past(e_byte[0])) else $error("display on/off not taken");
    AST_START: assert property (plain_cmd && e_byte[7:6] == 2'h1 && s_hw_n
        |=> first_line_o == $past(e_byte[5:0])) else $error("start line not loaded");
    AST_COLUMN: assert property (plain_cmd && e_byte[7:4] == 4'h1 && s_hw_n
        |=> column_index_o[7:4] == $past(e_byte[3:0])) else $error("column high wrong");
    AST_WR_INC: assert property (dat_wr && s_hw_n
        |=> column_index_o == $past(column_index_o) + 8'h01) else $error("no increment");
    AST_RMW_RD: assert property (dat_rd && rmw_mode_o && s_hw_n
        |=> column_index_o == $past(column_index_o)) else $error("rmw read moved column");
    AST_EV_PAIR: assert property (is_cmd && state_ff == gcd_pkg::ST_EV && s_hw_n
        |=> contrast_level_o == $past(e_byte[5:0]) && state_ff == gcd_pkg::ST_CMD)
        else $error("contrast operand lost");
    AST_NOP: assert property (plain_cmd && e_byte == 8'hE3 && s_hw_n
        |=> $stable(display_on_o) && $stable(column_index_o) && $stable(contrast_level_o))
        else $error("nop changed state");
    AST_SOFT_RST: assert property (soft_rst
        |=> init_busy_ff && !display_on_o && column_index_o == 8'h00)
        else $error("software reset incomplete");
    AST_STATUS: assert property (!s_a0
        |=> data_o[7] == 1'b0 && data_o[3:0] == 4'h0 && data_o[5] == $past(display_on_o))
        else $error("status byte wrong");
    AST_FLOAT: assert property (s_cs_n |=> !data_oe_o)
        else $error("bus driven while deselected");
    AST_SAVE: assert property (!display_on_o && force_all_on_o |=> power_save_o)
        else $error("power save missed");
endmodule

// ==== verification/gcd_host.sv ====
/*
 * Host microcontroller model: 8080, 6800 and 4-line serial transfers.
 * Assumes the bench shows the decoder's byte on bus_i while it drives.
 */
`timescale 1ns/1ns
module gcd_host (
    input wire logic clock_i,
    input wire logic [7:0] bus_i,
    input wire logic oe_i,
    output logic chip_select_n_o,
    output logic data_cmd_sel_o,
    output logic wr_o,
    output logic rd_o,
    output logic cpu_style_o,
    output logic port_type_o,
    output logic [7:0] bus_o
);
    // unused serial pins high, serial clock parked low between frames
    task automatic mode(input logic par, input logic m68);
        port_type_o = par;
        cpu_style_o = m68;
        wr_o = 1'b1;
        rd_o = !m68;
        bus_o = 8'h3F;
    endtask

    initial begin
        chip_select_n_o = 1'b1;
        data_cmd_sel_o = 1'b0;
        mode(1'b1, 1'b0);
    end

    // reserved test codes are never sent
    // a released bus shows the inverse of the last byte, never a stale copy
    task automatic xfer(input logic sel, input logic a0, input logic rd, input logic [7:0] b,
                        output logic [7:0] q, output logic oe);
        @(negedge clock_i);
        chip_select_n_o = !sel;
        data_cmd_sel_o = a0;
        bus_o = b;
        if (cpu_style_o) wr_o = rd;
        repeat (2) @(negedge clock_i);
        if (cpu_style_o) rd_o = 1'b1;
        else if (rd) rd_o = 1'b0;
        else wr_o = 1'b0;
        repeat (6) @(negedge clock_i);
        q = bus_i;
        oe = oe_i;
        rd_o = !cpu_style_o;
        if (!cpu_style_o) wr_o = 1'b1;
        repeat (3) @(negedge clock_i);
        chip_select_n_o = 1'b1;
        bus_o = ~b;
        wr_o = 1'b1;
    endtask

    // 80 ns serial clock: four system cycles per phase, moved only on falling edges
    task automatic ser(input logic a0, input logic [7:0] b);
        @(negedge clock_i);
        chip_select_n_o = 1'b0;
        data_cmd_sel_o = a0;
        for (int i = 7; i >= 0; i--) begin
            bus_o[7] = b[i];
            repeat (4) @(negedge clock_i);
            bus_o[6] = 1'b1;
            repeat (4) @(negedge clock_i);
            bus_o[6] = 1'b0;
        end
        repeat (4) @(negedge clock_i);
        chip_select_n_o = 1'b1;
        bus_o[7] = !b[0];
    endtask
endmodule

// ==== verification/test_glcd_command_decoder.sv ====
/*
 * Self-checking bench of the display command decoder with a host model.
 * Assumes a 100 MHz clock and a shortened initialization count.
 */
`timescale 1ns/1ns
module test_glcd_command_decoder;
    localparam int INIT = 5;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic hw_reset_n = 1'b1;
    logic csn, dcs, wr, rd, m68, par, d_oe, oe;
    logic disp, seg, com, invert_pixels, allon, bias, mult, pump, regon, foll, psave, rmw, busy;
    logic [7:0] h_bus, d_q, bus, q, col;
    logic [5:0] line, contrast;
    logic [3:0] page;
    logic [2:0] regul;
    int bad_count = 0;
    int num_checks = 0;

    always #5 clock_i = !clock_i;
    assign bus = d_oe ? d_q : h_bus;

    gcd_host host (.clock_i(clock_i), .bus_i(bus), .oe_i(d_oe), .chip_select_n_o(csn),
        .data_cmd_sel_o(dcs), .wr_o(wr), .rd_o(rd), .cpu_style_o(m68), .port_type_o(par),
        .bus_o(h_bus));

    gcd_decoder #(.INIT_CYCLES(INIT)) dut (.clock_i(clock_i), .rst_i(rst_i),
        .chip_select_n_i(csn), .hw_reset_n_i(hw_reset_n), .data_cmd_sel_i(dcs),
        .rw_or_write_strobe_i(wr), .enable_or_read_strobe_i(rd), .cpu_style_sel_i(m68),
        .port_type_sel_i(par), .data_i(bus), .data_o(d_q), .data_oe_o(d_oe),
        .display_on_o(disp), .first_line_o(line), .page_index_o(page), .column_index_o(col),
        .seg_reverse_o(seg), .com_reverse_o(com), .invert_pixels_o(invert_pixels),
        .force_all_on_o(allon), .bias_choice_o(bias), .pump_multiplier_o(mult),
        .contrast_level_o(contrast), .regul_ratio_o(regul), .pump_on_o(pump),
        .regulator_on_o(regon), .follower_on_o(foll), .power_save_o(psave),
        .rmw_mode_o(rmw), .init_busy_o(busy));

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // fixed settle time: sync, fifo and execute take about five cycles
    task automatic send(input logic a0, input logic [7:0] b);
        host.xfer(1'b1, a0, 1'b0, b, q, oe);
        repeat (12) @(negedge clock_i);
    endtask

    task automatic fetch(input logic a0);
        host.xfer(1'b1, a0, 1'b1, 8'h00, q, oe);
        repeat (4) @(negedge clock_i);
    endtask

    task automatic sput(input logic a0, input logic [7:0] b);
        host.ser(a0, b);
        repeat (12) @(negedge clock_i);
    endtask

    task automatic column(input logic [7:0] c);
        send(1'b0, {4'h1, c[7:4]});
        send(1'b0, {4'h0, c[3:0]});
    endtask

    function automatic logic [5:0] flags();
        return {disp, seg, invert_pixels, allon, bias, com};
    endfunction

    task automatic t_reset();
        chk("busy_in_reset", 8'h01, {7'h0, busy});
        @(negedge clock_i);
        rst_i = 1'b0;
        chk("contrast_rst", 8'h20, {2'h0, contrast});
        chk("regul_rst", 8'h05, {5'h0, regul});
        chk("flags_rst", 8'h00, {2'h0, flags()});
        chk("oe_idle", 8'h00, {7'h0, d_oe});
        repeat (INIT + 6) @(negedge clock_i);
        chk("busy_after", 8'h00, {7'h0, busy});
    endtask

    task automatic t_flags();
        logic [7:0] on_c[6];
        logic [7:0] off_c[6];
        logic [5:0] e;
        on_c = '{8'hAF, 8'hA1, 8'hA7, 8'hA5, 8'hA3, 8'hCF};
        off_c = '{8'hAE, 8'hA0, 8'hA6, 8'hA4, 8'hA2, 8'hC0};
        e = 6'h00;
        for (int i = 0; i < 6; i++) begin
            send(1'b0, on_c[i]);
            e[5 - i] = 1'b1;
            chk("flags_on", {2'h0, e}, {2'h0, flags()});
        end
        chk("psave_lit", 8'h00, {7'h0, psave});
        for (int i = 0; i < 6; i++) begin
            send(1'b0, off_c[i]);
            e[5 - i] = 1'b0;
            chk("flags_off", {2'h0, e}, {2'h0, flags()});
        end
        send(1'b0, 8'hA5);
        chk("psave_on", 8'h01, {7'h0, psave});
        send(1'b0, 8'hA4);
        chk("psave_off", 8'h00, {7'h0, psave});
    endtask

    task automatic t_values();
        send(1'b0, 8'h2D);
        chk("power", 8'h05, {5'h0, pump, regon, foll});
        send(1'b0, 8'h23);
        chk("regul", 8'h03, {5'h0, regul});
        send(1'b0, 8'h7F);
        chk("line", 8'h3F, {2'h0, line});
        send(1'b0, 8'hB5);
        chk("page", 8'h05, {4'h0, page});
        column(8'hA3);
        chk("column", 8'hA3, col);
        send(1'b0, 8'h81);
        send(1'b0, 8'h15);
        chk("contrast", 8'h15, {2'h0, contrast});
        send(1'b0, 8'hFC);
        send(1'b0, 8'h01);
        chk("mult", 8'h01, {7'h0, mult});
        send(1'b0, 8'hE3);
        chk("nop_col", 8'hA3, col);
        chk("nop_ev", 8'h15, {2'h0, contrast});
    endtask

    task automatic t_data();
        send(1'b0, 8'hB2);
        column(8'h10);
        for (int i = 0; i < 3; i++) send(1'b1, 8'h5A + 8'(i));
        chk("col_wr", 8'h13, col);
        column(8'h10);
        for (int i = 0; i < 3; i++) begin
            fetch(1'b1);
            chk("ram", 8'h5A + 8'(i), q);
            chk("ram_oe", 8'h01, {7'h0, oe});
        end
        chk("col_rd", 8'h13, col);
    endtask

    task automatic t_rmw();
        column(8'h20);
        send(1'b0, 8'hE0);
        chk("rmw_on", 8'h01, {7'h0, rmw});
        fetch(1'b1);
        chk("col_rmw_rd", 8'h20, col);
        send(1'b1, 8'hC3);
        chk("col_rmw_wr", 8'h21, col);
        send(1'b0, 8'hEE);
        chk("rmw_off", 8'h00, {7'h0, rmw});
        column(8'h20);
        fetch(1'b1);
        chk("rmw_ram", 8'hC3, q);
        chk("col_after", 8'h21, col);
    endtask

    task automatic t_status();
        send(1'b0, 8'hA1);
        send(1'b0, 8'hAF);
        fetch(1'b0);
        chk("status", 8'h60, q);
        host.xfer(1'b0, 1'b0, 1'b0, 8'hAE, q, oe);
        repeat (12) @(negedge clock_i);
        chk("cs_high_wr", 8'h01, {7'h0, disp});
        host.xfer(1'b0, 1'b0, 1'b1, 8'h00, q, oe);
        chk("cs_high_oe", 8'h00, {7'h0, oe});
    endtask

    task automatic t_soft();
        int seen;
        seen = 0;
        fork
            send(1'b0, 8'hE2);
            repeat (24) begin
                @(negedge clock_i);
                if (busy === 1'b1) seen++;
            end
        join
        chk("busy_seen", 8'h01, {7'h0, seen >= INIT});
        chk("busy_end", 8'h00, {7'h0, busy});
        chk("flags_sw", 8'h00, {2'h0, flags()});
        chk("ev_sw", 8'h20, {2'h0, contrast});
        chk("col_sw", 8'h00, col);
        fetch(1'b0);
        chk("status_sw", 8'h00, q);
    endtask

    task automatic t_hw();
        send(1'b0, 8'hAF);
        hw_reset_n = 1'b0;
        repeat (6) @(negedge clock_i);
        chk("hw_busy", 8'h01, {7'h0, busy});
        chk("hw_disp", 8'h00, {7'h0, disp});
        hw_reset_n = 1'b1;
        repeat (INIT + 8) @(negedge clock_i);
        chk("hw_done", 8'h00, {7'h0, busy});
    endtask

    task automatic t_serial();
        host.mode(1'b0, 1'b0);
        sput(1'b0, 8'hAF);
        chk("ser_disp", 8'h01, {7'h0, disp});
        sput(1'b0, 8'hB7);
        chk("ser_page", 8'h07, {4'h0, page});
        sput(1'b0, 8'h10);
        sput(1'b0, 8'h04);
        sput(1'b1, 8'h9C);
        chk("ser_col", 8'h05, col);
        host.mode(1'b1, 1'b0);
        column(8'h04);
        fetch(1'b1);
        chk("ser_ram", 8'h9C, q);
    endtask

    task automatic t_6800();
        host.mode(1'b1, 1'b1);
        send(1'b0, 8'hA7);
        chk("m68_inv", 8'h01, {7'h0, invert_pixels});
        fetch(1'b0);
        chk("m68_status", 8'h20, q);
        host.mode(1'b1, 1'b0);
    endtask

    initial begin
        repeat (11) @(negedge clock_i);
        t_reset();
        t_flags();
        t_values();
        t_data();
        t_rmw();
        t_status();
        t_soft();
        t_hw();
        t_serial();
        t_6800();
        results();
    end

    // about 1750 cycles are expected; allow over twenty times that
    initial begin
        #400000;
        bad_count++;
        results();
    end
endmodule
